// >>> rtl/frc_rate_config_and_status.sv
// frc_rate_config_and_status: rate config register, main status register
// and first end-status byte of a floppy controller host interface
// assumes host strobes are synchronous to sys_clk and the sequencer
// reports phases and events as single-cycle pulses or levels
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - rate bits pick 500/300/250/125K, reset 500K (250K in single density); the 125K cell strobe uses the 250K period
// - high-end mode: nonzero rate bits give 250K
// - high-end mode: config bit two reads one
// - high-end mode: bit four on disables precomp
// - legacy mode: bit two flop disables precomp
// - main status eight bits, readable any time
// - request and direction set within limit after byte
// - busy clears within limit after last result read
// - seek bits per drive; refuse read/write while seeking
// - busy during read/write; refuse other commands
// - execution flag only in execution, non-DMA
// - direction bit one means processor reads
// - request bit set when data register ready
// - end code 00 normal, 01 abnormal, 10 invalid
// - seek end flag set on seek completion
// - recalibrate 255 steps without track zero sets check
// - not-ready flag always reads zero
// - head state and unit number at interrupt
// - config captures low bits on write address 111
// - rate change switches clock without glitch
module frc_rate_config_and_status (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // host bus
  input  wire logic                  hostCs_n,
  input  wire logic                  hostRd_n,
  input  wire logic                  hostWr_n,
  input  wire logic [2:0]            hostAddr,
  input  wire logic [7:0]            hostDataIn,
  output logic [7:0]                 hostDataOut,
  output logic                       hostDataOe,
  // mode straps
  input  wire logic                  highEndMode,
  input  wire logic                  singleDensity,
  input  wire logic                  dmaMode,
  // sequencer phases
  input  wire logic                  cmdPhase,
  input  wire logic                  execPhase,
  input  wire logic                  resultPhase,
  input  wire logic                  lastResultByte,
  input  wire logic                  rwCmdActive,
  input  wire logic                  cmdIsReadWrite,
  input  wire logic                  cmdStart,
  input  wire logic [3:0]            driveSeekingIn,
  input  wire frc_pkg::frc_seq_event_s seqEvent,
  // results to the sequencer and drive logic
  output logic                       cmdRefused,
  output logic                       precompEnable,
  output logic                       fmMode,
  output frc_pkg::frc_rate_e         rateActive,
  output logic                       cellStrobe,
  output frc_pkg::frc_main_status_s  mainStatus,
  output frc_pkg::frc_end_status_s   endStatus
);
  import frc_pkg::*;

  // configuration state
  logic [1:0]       rateBits_q, rateBits_d;
  logic             cfgTwo_q, cfgTwo_d;
  logic             precompFour_q, precompFour_d;
  // handshake state
  logic             ready_q, ready_d;
  logic             dirRead_q, dirRead_d;
  logic             busy_q, busy_d;
  logic [TIMER_W-1:0] settle_q, settle_d;
  logic [TIMER_W-1:0] busyTmr_q, busyTmr_d;
  logic             busyDrop_q, busyDrop_d;
  logic             rdSeen_q, rdSeen_d;
  // end status state
  frc_end_status_s  st0_q, st0_d;
  logic [7:0]       recalCnt_q, recalCnt_d;
  logic             recalOn_q, recalOn_d;
  // read data
  logic [7:0]       rdData_q, rdData_d;
  logic             rdOe_q, rdOe_d;

  logic             cfgWrite;
  logic             dataAccess;
  logic             statusRead;
  logic             rdTrail;
  logic             configTwoView;
  frc_rate_e        rateReq;
  logic             anySeek;

  assign cfgWrite   = !hostCs_n && !hostWr_n && (hostAddr == ADDR_RATE_CTRL);
  assign dataAccess = !hostCs_n && (!hostWr_n || !hostRd_n) && (hostAddr == ADDR_DATA);
  assign statusRead = !hostCs_n && !hostRd_n && (hostAddr == ADDR_MAIN_STATUS);
  // trailing edge: read strobe seen last cycle, now released
  assign rdTrail    = rdSeen_q && hostRd_n;
  assign anySeek    = |driveSeekingIn;

  frc_rate_decode u_decode (
    .rateBits      (rateBits_q),
    .highEndMode   (highEndMode),
    .singleDensity (singleDensity),
    .fmMode        (fmMode),
    .rateSel       (rateReq)
  );

  frc_rate_switch u_switch (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .rateReq    (rateReq),
    .cellStrobe (cellStrobe),
    .rateActive (rateActive)
  );

  // configuration register
  always_comb begin
    rateBits_d    = rateBits_q;
    cfgTwo_d      = cfgTwo_q;
    precompFour_d = precompFour_q;
    if (cfgWrite) begin
      rateBits_d = {hostDataIn[RATE_HI_POS], hostDataIn[RATE_LO_POS]};
      if (!highEndMode) begin
        cfgTwo_d = hostDataIn[CFG_TWO_POS];
      end
      // bit four only exists as a control in high-end mode; the rest drop
      if (highEndMode) begin
        precompFour_d = hostDataIn[PRECOMP4_POS];
      end
    end
  end

  // in high-end mode bit two has no storage and is seen as one
  assign configTwoView = highEndMode ? 1'b1 : cfgTwo_q;
  assign precompEnable = highEndMode ? !precompFour_q : !configTwoView;

  // handshake: request drops on each command or result byte and returns after a settle
  always_comb begin
    ready_d    = ready_q;
    dirRead_d  = dirRead_q;
    settle_d   = settle_q;
    busy_d     = busy_q;
    busyTmr_d  = busyTmr_q;
    busyDrop_d = busyDrop_q;
    rdSeen_d   = !hostCs_n && !hostRd_n && (hostAddr == ADDR_DATA);
    dirRead_d  = resultPhase || (execPhase && dirRead_q);
    if (dataAccess && (cmdPhase || resultPhase)) begin
      ready_d  = 1'b0;
      // the settle ends exactly on the allowed limit, never longer
      settle_d = limitFor(rateActive) - TIMER_W'(1);
    end else if (!ready_q) begin
      if (settle_q == '0) begin
        ready_d = cmdPhase || resultPhase || (execPhase && !dmaMode);
      end else begin
        settle_d = settle_q - TIMER_W'(1);
      end
    end else if (!(cmdPhase || resultPhase || (execPhase && !dmaMode))) begin
      ready_d = 1'b0;
    end
    if (rdTrail && lastResultByte) begin
      busyDrop_d = 1'b1;
      // the release is seen half a cycle late, so the count is two short
      busyTmr_d  = TIMER_W'(BUSY_LIMIT_CYC) - TIMER_W'(2);
    end else if (busyDrop_q) begin
      if (busyTmr_q == '0) begin
        busy_d     = 1'b0;
        busyDrop_d = 1'b0;
      end else begin
        busyTmr_d = busyTmr_q - TIMER_W'(1);
      end
    end
    // a read/write starting as the drop expires keeps busy set
    if (cmdStart && cmdIsReadWrite && !anySeek) begin
      busy_d = 1'b1;
    end else if (rwCmdActive) begin
      busy_d = 1'b1;
    end
  end

  // a read/write is refused while seeking, anything while busy
  assign cmdRefused = cmdStart && (busy_q || (cmdIsReadWrite && anySeek));

  always_comb begin
    mainStatus                      = '0;
    mainStatus.driveSeeking         = driveSeekingIn;
    mainStatus.controllerBusy       = busy_q;
    mainStatus.executionPhaseFlag   = execPhase && !dmaMode;
    mainStatus.transferDirection    = dirRead_q;
    mainStatus.registerReadyRequest = ready_q;
  end

  // first end-status byte
  always_comb begin
    st0_d      = st0_q;
    recalCnt_d = recalCnt_q;
    recalOn_d  = recalOn_q;
    if (seqEvent.recalStart) begin
      recalOn_d  = 1'b1;
      recalCnt_d = '0;
      st0_d.equipmentCheck = 1'b0;
    end else if (recalOn_q && seqEvent.trackZero) begin
      recalOn_d = 1'b0;
    end else if (recalOn_q && seqEvent.recalStep) begin
      if (recalCnt_q == RECAL_STEP_MAX - 8'h01) begin
        st0_d.equipmentCheck = 1'b1;
        recalOn_d            = 1'b0;
      end
      recalCnt_d = recalCnt_q + 8'h01;
    end
    if (cmdStart) begin
      st0_d.seekComplete = 1'b0;
    end
    if (seqEvent.cmdEnd) begin
      st0_d.terminationCode = seqEvent.endCode;
      st0_d.headState       = seqEvent.headState;
      st0_d.unitNumberHigh  = seqEvent.unitNumber[1];
      st0_d.unitNumberLow   = seqEvent.unitNumber[0];
    end
    if (cmdRefused) begin
      st0_d.terminationCode = TERM_INVALID;
    end
    // set after the clear so a completing seek is not lost
    if (seqEvent.seekDone) begin
      st0_d.seekComplete = 1'b1;
    end
    st0_d.driveNotReady = 1'b0;
  end

  always_comb begin
    rdData_d = rdData_q;
    rdOe_d   = statusRead;
    if (statusRead) begin
      rdData_d = mainStatus;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rateBits_q    <= RATE_RESET;
      cfgTwo_q      <= CFG_TWO_RESET;
      precompFour_q <= PRECOMP4_RESET;
      ready_q       <= 1'b1;
      dirRead_q     <= 1'b0;
      busy_q        <= 1'b0;
      settle_q      <= '0;
      busyTmr_q     <= '0;
      busyDrop_q    <= 1'b0;
      rdSeen_q      <= 1'b0;
      st0_q         <= '0;
      recalCnt_q    <= '0;
      recalOn_q     <= 1'b0;
      rdData_q      <= '0;
      rdOe_q        <= 1'b0;
    end else begin
      rateBits_q    <= rateBits_d;
      cfgTwo_q      <= cfgTwo_d;
      precompFour_q <= precompFour_d;
      ready_q       <= ready_d;
      dirRead_q     <= dirRead_d;
      busy_q        <= busy_d;
      settle_q      <= settle_d;
      busyTmr_q     <= busyTmr_d;
      busyDrop_q    <= busyDrop_d;
      rdSeen_q      <= rdSeen_d;
      st0_q         <= st0_d;
      recalCnt_q    <= recalCnt_d;
      recalOn_q     <= recalOn_d;
      rdData_q      <= rdData_d;
      rdOe_q        <= rdOe_d;
    end
  end

  assign hostDataOut = rdData_q;
  assign hostDataOe  = rdOe_q;
  assign endStatus   = st0_q;

endmodule : frc_rate_config_and_status
`default_nettype wire

// >>> rtl/frc_pkg.sv
// frc_pkg: constants, types and encodings for the rate config and status block
// assumes a 250 MHz sys_clk; shared by every rtl file of the block
package frc_pkg;

  localparam int unsigned CLK_MHZ        = 250;
  // handshake settle limits, microseconds as printed
  localparam int unsigned RQM_LIMIT_US   = 12;
  localparam int unsigned RQM_SLOW_US    = 24;
  localparam int unsigned BUSY_LIMIT_US  = 12;
  // cycles are rounded down from the longest allowed time
  localparam int unsigned RQM_LIMIT_CYC  = RQM_LIMIT_US * CLK_MHZ;
  localparam int unsigned RQM_SLOW_CYC   = RQM_SLOW_US * CLK_MHZ;
  localparam int unsigned BUSY_LIMIT_CYC = BUSY_LIMIT_US * CLK_MHZ;
  localparam int unsigned TIMER_W        = 16;

  // host register address decode (three address bits)
  localparam logic [2:0] ADDR_MAIN_STATUS = 3'h4;
  localparam logic [2:0] ADDR_DATA        = 3'h5;
  localparam logic [2:0] ADDR_RATE_CTRL   = 3'h7;

  // configuration field positions
  localparam int unsigned RATE_LO_POS     = 0;
  localparam int unsigned RATE_HI_POS     = 1;
  localparam int unsigned CFG_TWO_POS     = 2;
  localparam int unsigned PRECOMP4_POS    = 4;

  localparam logic [1:0] RATE_RESET       = 2'h0;
  localparam logic       CFG_TWO_RESET    = 1'b0;
  localparam logic       PRECOMP4_RESET   = 1'b0;
  localparam logic [1:0] RATE_CODE_250    = 2'h2;

  // command end codes
  localparam logic [1:0] TERM_NORMAL      = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL    = 2'h1;
  localparam logic [1:0] TERM_INVALID     = 2'h2;

  localparam logic [7:0] RECAL_STEP_MAX   = 8'hFF;

  typedef enum logic [2:0] {
    RATE_500K, RATE_300K, RATE_250K, RATE_125K
  } frc_rate_e;

  typedef struct packed {
    logic        registerReadyRequest;
    logic        transferDirection;
    logic        executionPhaseFlag;
    logic        controllerBusy;
    logic [3:0]  driveSeeking;
  } frc_main_status_s;

  typedef struct packed {
    logic [1:0]  terminationCode;
    logic        seekComplete;
    logic        equipmentCheck;
    logic        driveNotReady;
    logic        headState;
    logic        unitNumberHigh;
    logic        unitNumberLow;
  } frc_end_status_s;

  // sequencer events that feed the end status byte
  typedef struct packed {
    logic        cmdEnd;
    logic [1:0]  endCode;
    logic        seekDone;
    logic        recalStep;
    logic        recalStart;
    logic        trackZero;
    logic        headState;
    logic [1:0]  unitNumber;
  } frc_seq_event_s;

  function automatic logic [TIMER_W-1:0] limitFor(input frc_rate_e r);
    // the 250K and 125K rates double the settle allowance; 300K keeps the 500K limit
    if (r == RATE_500K || r == RATE_300K) begin
      limitFor = TIMER_W'(RQM_LIMIT_CYC);
    end else begin
      limitFor = TIMER_W'(RQM_SLOW_CYC);
    end
  endfunction : limitFor

endpackage : frc_pkg

// >>> rtl/frc_rate_decode.sv
// frc_rate_decode: maps the stored rate bits and mode straps to a rate
// assumes static mode inputs; purely combinational
`timescale 1ns/1ns
`default_nettype none
module frc_rate_decode (
  // configuration
  input  wire logic [1:0]         rateBits,
  input  wire logic               highEndMode,
  input  wire logic               singleDensity,
  // result
  output logic                    fmMode,
  output frc_pkg::frc_rate_e      rateSel
);
  import frc_pkg::*;

  always_comb begin
    fmMode  = singleDensity;
    rateSel = RATE_500K;
    if (highEndMode) begin
      // high-end systems only know 500K and 250K
      rateSel = (rateBits == RATE_RESET) ? RATE_500K : RATE_250K;
    end else if (singleDensity) begin
      case (rateBits)
        2'h0:    rateSel = RATE_250K;
        default: rateSel = RATE_125K;
      endcase
    end else begin
      case (rateBits)
        2'h0:    rateSel = RATE_500K;
        2'h1:    rateSel = RATE_300K;
        2'h2:    rateSel = RATE_250K;
        default: rateSel = RATE_125K;
      endcase
    end
  end

endmodule : frc_rate_decode
`default_nettype wire

// >>> rtl/frc_rate_switch.sv
// frc_rate_switch: glitch-free change of rate by applying a new rate only
// at the boundary of the bit-cell strobe; assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
module frc_rate_switch (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // requested rate
  input  wire frc_pkg::frc_rate_e rateReq,
  // generated bit-cell strobe and active rate
  output logic                    cellStrobe,
  output frc_pkg::frc_rate_e      rateActive
);
  import frc_pkg::*;

  logic [9:0]  divCnt_q, divCnt_d;
  frc_rate_e   rate_q, rate_d;
  logic        strobe_q, strobe_d;
  logic [9:0]  divMax;

  function automatic logic [9:0] divFor(input frc_rate_e r);
    case (r)
      RATE_500K: divFor = 10'h1F3;
      RATE_300K: divFor = 10'h340;
      RATE_250K: divFor = 10'h3E7;
      default:   divFor = 10'h3E7;
    endcase
  endfunction : divFor

  assign divMax = divFor(rate_q);

  always_comb begin
    divCnt_d = divCnt_q + 10'h001;
    rate_d   = rate_q;
    strobe_d = 1'b0;
    if (divCnt_q >= divMax) begin
      divCnt_d = 10'h000;
      strobe_d = 1'b1;
      // the new rate takes over only at a whole period, so no short cell
      rate_d   = rateReq;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= 10'h000;
      rate_q   <= RATE_500K;
      strobe_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      rate_q   <= rate_d;
      strobe_q <= strobe_d;
    end
  end

  assign cellStrobe = strobe_q;
  assign rateActive = rate_q;

endmodule : frc_rate_switch
`default_nettype wire

// >>> testbench/frc_rate_config_and_status_sva.sv
// checker of the rate config and status block, top module ports only
// assumes one clock domain; attached to every top instance by bind
`timescale 1ns/1ns
`default_nettype none
module frc_rate_config_and_status_sva (
  // clock and reset
  input wire logic                      sys_clk,
  input wire logic                      rst,
  // host bus
  input wire logic                      hostCs_n,
  input wire logic                      hostRd_n,
  input wire logic                      hostWr_n,
  input wire logic [2:0]                hostAddr,
  input wire logic [7:0]                hostDataIn,
  input wire logic [7:0]                hostDataOut,
  input wire logic                      hostDataOe,
  // straps and sequencer
  input wire logic                      highEndMode,
  input wire logic                      dmaMode,
  input wire logic                      execPhase,
  input wire logic                      cmdPhase,
  input wire logic                      resultPhase,
  input wire logic                      cmdIsReadWrite,
  input wire logic                      cmdStart,
  input wire logic [3:0]                driveSeekingIn,
  input wire frc_pkg::frc_seq_event_s   seqEvent,
  // results
  input wire logic                      cmdRefused,
  input wire logic                      precompEnable,
  input wire frc_pkg::frc_main_status_s mainStatus,
  input wire frc_pkg::frc_end_status_s  endStatus
);
  import frc_pkg::*;
  logic cfgWr;
  logic stRd;
  logic        waitOn_q;
  logic [15:0] waitCnt_q;
  assign cfgWr = !hostCs_n && !hostWr_n && hostAddr == ADDR_RATE_CTRL;
  assign stRd  = !hostCs_n && !hostRd_n && hostAddr == ADDR_MAIN_STATUS;
  // cycles since a handshake byte; forgotten once the phase ends
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitOn_q  <= 1'b0;
      waitCnt_q <= 16'h0000;
    end else if (!hostCs_n && hostAddr == ADDR_DATA && !(hostRd_n && hostWr_n)) begin
      waitOn_q  <= cmdPhase || resultPhase;
      waitCnt_q <= 16'h0000;
    end else if (mainStatus.registerReadyRequest || !(cmdPhase || resultPhase)) begin
      waitOn_q  <= 1'b0;
    end else begin
      waitCnt_q <= waitCnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  status_read_a: assert property (stRd |=> hostDataOe && hostDataOut == $past(mainStatus))
    else $error("status read returned wrong byte");
  precomp_high_a: assert property (cfgWr && highEndMode |=>
    precompEnable == !$past(hostDataIn[PRECOMP4_POS])) else $error("high-end precomp wrong");
  precomp_low_a: assert property (cfgWr && !highEndMode |=>
    precompEnable == !$past(hostDataIn[CFG_TWO_POS])) else $error("legacy precomp wrong");
  seek_bits_a: assert property (mainStatus.driveSeeking == driveSeekingIn)
    else $error("seek bits differ");
  refuse_seek_a: assert property (cmdStart && cmdIsReadWrite && (|driveSeekingIn) |-> cmdRefused)
    else $error("read or write accepted while seeking");
  refuse_busy_a: assert property (cmdStart && mainStatus.controllerBusy |-> cmdRefused)
    else $error("command accepted while busy");
  exec_flag_a: assert property (mainStatus.executionPhaseFlag |-> execPhase && !dmaMode)
    else $error("execution flag outside non-DMA execution");
  end_code_a: assert property (seqEvent.cmdEnd && !cmdStart |=>
    {endStatus.terminationCode, endStatus.headState, endStatus.unitNumberHigh,
     endStatus.unitNumberLow} == $past({seqEvent.endCode, seqEvent.headState, seqEvent.unitNumber}))
    else $error("end status fields wrong");
  seek_flag_a: assert property (seqEvent.seekDone |=> endStatus.seekComplete)
    else $error("seek end flag not set");
  not_ready_a: assert property (!endStatus.driveNotReady)
    else $error("not-ready flag set");
  ready_back_a: assert property (waitOn_q |-> waitCnt_q <= 16'(RQM_SLOW_CYC))
    else $error("ready did not return");
endmodule : frc_rate_config_and_status_sva

bind frc_rate_config_and_status frc_rate_config_and_status_sva chk_u (
  .sys_clk(sys_clk), .rst(rst), .hostCs_n(hostCs_n), .hostRd_n(hostRd_n),
  .hostWr_n(hostWr_n), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
  .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .highEndMode(highEndMode),
  .dmaMode(dmaMode), .execPhase(execPhase), .cmdIsReadWrite(cmdIsReadWrite),
  .cmdPhase(cmdPhase), .resultPhase(resultPhase),
  .cmdStart(cmdStart), .driveSeekingIn(driveSeekingIn), .seqEvent(seqEvent),
  .cmdRefused(cmdRefused), .precompEnable(precompEnable), .mainStatus(mainStatus),
  .endStatus(endStatus));
`default_nettype wire

// >>> testbench/frc_host_model.sv
// host processor model: single-cycle bus accesses at the falling edge
// assumes the block samples the strobes on the rising edge of sys_clk
`timescale 1ns/1ns
`default_nettype none
module frc_host_model (
  // clock
  input  wire logic       sys_clk,
  // host bus
  output logic            hostCs_n,
  output logic            hostRd_n,
  output logic            hostWr_n,
  output logic [2:0]      hostAddr,
  output logic [7:0]      hostDataIn,
  input  wire logic [7:0] hostDataOut
);
  import frc_pkg::*;
  initial begin
    {hostCs_n, hostRd_n, hostWr_n} = 3'h7;
    hostAddr = 3'h0;
    hostDataIn = 8'h00;
  end

  task automatic busCycle(input logic [2:0] a, input logic wr, input logic [7:0] d);
    @(negedge sys_clk);
    hostCs_n = 1'b0;
    hostAddr = a;
    hostRd_n = wr;
    hostWr_n = !wr;
    hostDataIn = d;
    @(negedge sys_clk);
    {hostCs_n, hostRd_n, hostWr_n} = 3'h7;
    // a released bus must not keep showing the last address or data
    hostAddr = ~a;
    hostDataIn = ~d;
  endtask : busCycle

  task automatic statusRead(output logic [7:0] st);
    busCycle(ADDR_MAIN_STATUS, 1'b0, 8'h00);
    @(posedge sys_clk);
    #1;
    st = hostDataOut;
  endtask : statusRead

  // polling the two handshake bits replaces the fixed settle wait
  task automatic pollAccess(input logic wr, input logic [7:0] d);
    logic [7:0] st;
    int         n;
    n = 0;
    do begin
      statusRead(st);
      n++;
    end while (!(st[7] === 1'b1 && st[6] === !wr) && n < 8000);
    busCycle(ADDR_DATA, wr, d);
  endtask : pollAccess
endmodule : frc_host_model
`default_nettype wire

// >>> testbench/frc_rate_config_and_status_tb.sv
// testbench of the rate config and status block with a host model
// assumes the checker is bound to the top module; 250 MHz sys_clk
`timescale 1ns/1ns
`default_nettype none
module frc_rate_config_and_status_tb;
  import frc_pkg::*;
  logic             sys_clk, rst, hostCs_n, hostRd_n, hostWr_n, hostDataOe;
  logic [2:0]       hostAddr;
  logic [7:0]       hostDataIn, hostDataOut;
  logic             highEndMode, singleDensity, dmaMode, cmdPhase, execPhase, resultPhase;
  logic             lastResultByte, rwCmdActive, cmdIsReadWrite, cmdStart, cmdRefused;
  logic             precompEnable, fmMode, cellStrobe;
  logic [3:0]       driveSeekingIn;
  frc_seq_event_s   seqEv;
  frc_rate_e        rateActive;
  frc_main_status_s mainStatus;
  frc_end_status_s  endStatus;
  int               fail_count, num_checks;
  logic [15:0]      expQ[$];

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  frc_host_model host_u (.sys_clk(sys_clk), .hostCs_n(hostCs_n), .hostRd_n(hostRd_n),
    .hostWr_n(hostWr_n), .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut));
  frc_rate_config_and_status dut_u (.sys_clk(sys_clk), .rst(rst), .hostCs_n(hostCs_n),
    .hostRd_n(hostRd_n), .hostWr_n(hostWr_n), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .highEndMode(highEndMode),
    .singleDensity(singleDensity), .dmaMode(dmaMode), .cmdPhase(cmdPhase),
    .execPhase(execPhase), .resultPhase(resultPhase), .lastResultByte(lastResultByte),
    .rwCmdActive(rwCmdActive), .cmdIsReadWrite(cmdIsReadWrite), .cmdStart(cmdStart),
    .driveSeekingIn(driveSeekingIn), .seqEvent(seqEv), .cmdRefused(cmdRefused),
    .precompEnable(precompEnable), .fmMode(fmMode), .rateActive(rateActive),
    .cellStrobe(cellStrobe), .mainStatus(mainStatus), .endStatus(endStatus));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // status bytes seen by the host are compared under a mask, oldest note first
  always @(posedge sys_clk) begin
    logic [15:0] e;
    #1;
    if (hostDataOe === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      check("main status", hostDataOut & e[15:8], e[7:0]);
    end
  end

  task automatic stRead(input logic [7:0] mask, input logic [7:0] val);
    logic [7:0] st;
    expQ.push_back({mask, val});
    host_u.statusRead(st);
    repeat (2) @(negedge sys_clk);
  endtask : stRead

  task automatic setRate(input logic [7:0] d, input frc_rate_e e);
    host_u.busCycle(ADDR_RATE_CTRL, 1'b1, d);
    for (int k = 0; k < 5000 && rateActive !== e; k++) @(negedge sys_clk);
    check("rate", 8'(rateActive), 8'(e));
  endtask : setRate

  task automatic measure(input logic wr, input int limit);
    int n;
    host_u.pollAccess(wr, 8'($urandom));
    check("ready after access", 8'(mainStatus.registerReadyRequest), 8'h00);
    for (n = 0; n < 7000 && mainStatus.registerReadyRequest !== 1'b1; n++) @(negedge sys_clk);
    check("ready delay", 8'(n <= limit), 8'h01);
  endtask : measure

  task automatic startCmd(input logic rw, input logic refused);
    @(negedge sys_clk);
    cmdStart = 1'b1;
    cmdIsReadWrite = rw;
    #1;
    check("refused", 8'(cmdRefused), 8'(refused));
    @(negedge sys_clk);
    cmdStart = 1'b0;
  endtask : startCmd

  task automatic pulseEv(input frc_seq_event_s ev);
    @(negedge sys_clk);
    seqEv = ev;
    @(negedge sys_clk);
    seqEv = '0;
  endtask : pulseEv

  initial begin
    #400000;
    fail_count++;
    close_out();
  end

  initial begin
    frc_rate_e      e;
    frc_seq_event_s ev;
    logic [7:0]     d;
    logic [1:0]     c;
    logic           hem;
    logic           sd;
    int             n;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(32'hf0e3));
    {highEndMode, singleDensity, dmaMode, cmdPhase, execPhase, resultPhase} = '0;
    {lastResultByte, rwCmdActive, cmdIsReadWrite, cmdStart} = '0;
    driveSeekingIn = 4'h0;
    seqEv = '0;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    // idle awaits a command, so request stays up
    cmdPhase = 1'b1;
    check("reset rate", 8'(rateActive), 8'(RATE_500K));
    check("reset precomp", 8'(precompEnable), 8'h01);
    check("reset end status", endStatus, 8'h00);
    stRead(8'hff, 8'h80);
    cmdPhase = 1'b0;
    // legacy codes, high-end codes, then single density; upper bits random
    for (int i = 0; i < 10; i++) begin
      d = 8'($urandom);
      c = (i < 8) ? 2'(i) : {i[0], 1'b0};
      d[1:0] = c;
      hem = (i < 8) && i[2];
      sd = (i >= 8);
      @(negedge sys_clk);
      highEndMode = hem;
      singleDensity = sd;
      if (sd) e = (c == 2'h0) ? RATE_250K : RATE_125K;
      else if (hem) e = (c == 2'h0) ? RATE_500K : RATE_250K;
      else e = frc_rate_e'({1'b0, c});
      setRate(d, e);
      check("fm mode", 8'(fmMode), 8'(sd));
      check("precomp", 8'(precompEnable), 8'(hem ? !d[4] : !d[2]));
    end
    singleDensity = 1'b0;
    highEndMode = 1'b0;
    setRate(8'h00, RATE_500K);
    driveSeekingIn = 4'($urandom_range(15, 1));
    stRead(8'h1f, {4'h0, driveSeekingIn});
    startCmd(1'b1, 1'b1);
    check("refused code", 8'(endStatus.terminationCode), 8'(TERM_INVALID));
    startCmd(1'b0, 1'b0);
    driveSeekingIn = 4'h0;
    rwCmdActive = 1'b1;
    stRead(8'h1f, 8'h10);
    startCmd(1'b0, 1'b1);
    rwCmdActive = 1'b0;
    execPhase = 1'b1;
    stRead(8'h20, 8'h20);
    dmaMode = 1'b1;
    stRead(8'h20, 8'h00);
    {execPhase, dmaMode} = 2'h0;
    cmdPhase = 1'b1;
    measure(1'b1, RQM_LIMIT_CYC);
    stRead(8'hc0, 8'h80);
    setRate(8'h02, RATE_250K);
    measure(1'b1, RQM_SLOW_CYC);
    cmdPhase = 1'b0;
    resultPhase = 1'b1;
    stRead(8'hc0, 8'hc0);
    lastResultByte = 1'b1;
    host_u.pollAccess(1'b0, 8'h00);
    // hold the last-byte mark over the edge that sees the read released
    @(negedge sys_clk);
    {resultPhase, lastResultByte} = 2'h0;
    for (n = 0; n < 7000 && mainStatus.controllerBusy !== 1'b0; n++) @(negedge sys_clk);
    check("busy clear", 8'(n <= BUSY_LIMIT_CYC), 8'h01);
    for (int i = 0; i < 3; i++) begin
      ev = '0;
      ev.cmdEnd = 1'b1;
      ev.endCode = 2'(i);
      ev.headState = 1'($urandom);
      ev.unitNumber = 2'($urandom);
      pulseEv(ev);
      check("end status", endStatus & 8'hcf, {ev.endCode, 3'h0, ev.headState, ev.unitNumber});
    end
    ev = '0;
    ev.seekDone = 1'b1;
    pulseEv(ev);
    check("seek end", 8'(endStatus.seekComplete), 8'h01);
    ev = '0;
    ev.recalStart = 1'b1;
    pulseEv(ev);
    ev = '0;
    ev.recalStep = 1'b1;
    repeat (254) pulseEv(ev);
    check("check early", 8'(endStatus.equipmentCheck), 8'h00);
    pulseEv(ev);
    check("check at last step", 8'(endStatus.equipmentCheck), 8'h01);
    close_out();
  end
endmodule : frc_rate_config_and_status_tb
`default_nettype wire
